// file: logic/asc_seq_ctrl.sv
// Sequence controller of an 8-bit successive-approximation converter with
// channel mux, four result slots and an APB register file.
// Assumes an external analog mux, DAC array and comparator; cmp_above is
// synchronous to pclk and high when the sampled input is at or above dac_code.
`timescale 1ns/100ps

// Operation
// - Four-bit channel code; 0000 to 0111 route inputs 0 to 7 in order.
// - 1100 high ref, 1101 low ref, 1110 half high ref; others reserved.
// - Single channel, one-shot: convert four times into slots 1 to 4.
// - One-shot stops after fourth result until next control write.
// - Single channel continuous: results overwrite slots cyclically.
// - Group mode: upper code bits pick group, low bits n go to slot n+1.
// - Group one-shot: each of four channels converted exactly once.
// - Group continuous: cycle channels forever, each replacing its own slot.
// - Halt or idle suspends current channel; resume resamples it and continues.
// - Control bit 7 read-only, bit 6 reads zero, rest read and write.
// - Any control write abandons the sequence and restarts with new settings.
// - Control write clears the done flag until the new sequence completes.
// - Done flag set after four results; stays set in continuous scan.
// - Result slots are 8-bit read-only; writes ignored.
// - Each conversion takes 32 clock cycles; a group round takes 128.
// - Sequence begins one clock after the control write.
// - Eight comparisons MSB first, then value moves into its slot.
// - Converter runs only while power-on bit is set.
module asc_seq_ctrl (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire asc_pkg::asc_apb_req_t apb_i,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Low-power modes
  input  wire logic                  halt_req,
  input  wire logic                  idle_req,
  // Analog front end
  input  wire logic                  cmp_above,
  output logic [3:0]                 mux_sel,
  output logic                       mux_en,
  output logic                       sample_en,
  output logic [7:0]                 dac_code,
  output logic                       conv_power
);
  import asc_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] idx);
    reg_hit = (addr == {idx[13:0], 2'b00});
  endfunction

  function automatic logic chan_routable(input logic [3:0] code);
    chan_routable = (code <= ASC_CH_IN_LAST) || (code == ASC_CH_REF_HI) ||
                    (code == ASC_CH_REF_LO) || (code == ASC_CH_REF_MID);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  asc_state_t  st_r, st_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [1:0]  slot_r, slot_nxt;
  logic [7:0]  dac_r, dac_nxt;
  logic [7:0]  res_r [ASC_SLOTS];
  logic [7:0]  res_nxt [ASC_SLOTS];
  asc_ctrl_t   ctrl_r, ctrl_nxt;
  logic        done_r, done_nxt;
  logic        pwr_r, pwr_nxt;
  logic [3:0]  mux_r, mux_nxt;
  logic        muxen_r, muxen_nxt;
  logic        smp_r, smp_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [7:0]  bit_sel;
  logic [7:0]  kept;
  logic        setup, acc, hit_any, wr_ctrl, wr_cfg, susp;

  // ---------------------------------------------------------------
  // APB slave: one wait-free access, registered answer
  // ---------------------------------------------------------------
  assign setup   = apb_i.psel && !apb_i.penable;
  assign acc     = apb_i.psel && apb_i.penable && pready_r;
  assign hit_any = reg_hit(apb_i.paddr, ASC_IDX_CTRL) || reg_hit(apb_i.paddr, ASC_IDX_RES1) ||
                   reg_hit(apb_i.paddr, ASC_IDX_RES2) || reg_hit(apb_i.paddr, ASC_IDX_RES3) ||
                   reg_hit(apb_i.paddr, ASC_IDX_RES4) || reg_hit(apb_i.paddr, ASC_IDX_CFG);
  assign wr_ctrl = acc && apb_i.pwrite && reg_hit(apb_i.paddr, ASC_IDX_CTRL);
  assign wr_cfg  = acc && apb_i.pwrite && reg_hit(apb_i.paddr, ASC_IDX_CFG);

  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup && !hit_any;
    prdata_nxt  = '0;
    if (setup && !apb_i.pwrite) begin
      if (reg_hit(apb_i.paddr, ASC_IDX_CTRL)) begin
        prdata_nxt[ASC_BIT_DONE]  = done_r;
        prdata_nxt[ASC_BIT_ZERO]  = 1'b0;
        prdata_nxt[ASC_BIT_SCAN]  = ctrl_r.scan;
        prdata_nxt[ASC_BIT_GROUP] = ctrl_r.group;
        prdata_nxt[3:0]           = ctrl_r.sel;
      end else if (reg_hit(apb_i.paddr, ASC_IDX_RES1)) begin
        prdata_nxt[7:0] = res_r[0];
      end else if (reg_hit(apb_i.paddr, ASC_IDX_RES2)) begin
        prdata_nxt[7:0] = res_r[1];
      end else if (reg_hit(apb_i.paddr, ASC_IDX_RES3)) begin
        prdata_nxt[7:0] = res_r[2];
      end else if (reg_hit(apb_i.paddr, ASC_IDX_RES4)) begin
        prdata_nxt[7:0] = res_r[3];
      end else if (reg_hit(apb_i.paddr, ASC_IDX_CFG)) begin
        prdata_nxt[ASC_BIT_PWR] = pwr_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer, successive approximation and result slots
  // ---------------------------------------------------------------
  assign susp = halt_req || idle_req || !pwr_r;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    slot_nxt = slot_r;
    dac_nxt  = dac_r;
    res_nxt  = res_r;
    ctrl_nxt = ctrl_r;
    done_nxt = done_r;
    pwr_nxt  = pwr_r;
    bit_sel  = ASC_MSB_TRIAL >> (cnt_r - ASC_SAMPLE_END);
    kept     = cmp_above ? dac_r : (dac_r & ~bit_sel);
    if (wr_cfg) begin
      pwr_nxt = apb_i.pwdata[ASC_BIT_PWR];
    end
    case (st_r)
      ASC_IDLE: begin
        st_nxt = ASC_IDLE;
      end
      ASC_SUSP: begin
        if (!susp) begin
          st_nxt  = ASC_CONV;
          cnt_nxt = '0;
        end
      end
      ASC_CONV: begin
        if (susp) begin
          st_nxt  = ASC_SUSP;
          cnt_nxt = '0;
          dac_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == ASC_SAMPLE_LST) begin
            dac_nxt = ASC_MSB_TRIAL;
          end else if (cnt_r >= ASC_SAMPLE_END) begin
            dac_nxt = kept | (bit_sel >> 1);
            if (cnt_r == ASC_CNT_LAST) begin
              res_nxt[slot_r] = kept;
              slot_nxt        = slot_r + 2'd1;
              cnt_nxt         = '0;
              dac_nxt         = '0;
              if (slot_r == 2'd3) begin
                done_nxt = 1'b1;
                if (!ctrl_r.scan) begin
                  st_nxt = ASC_IDLE;
                end
              end
            end
          end
        end
      end
      default: begin
        st_nxt = ASC_IDLE;
      end
    endcase
    if (wr_ctrl) begin
      ctrl_nxt.scan  = apb_i.pwdata[ASC_BIT_SCAN];
      ctrl_nxt.group = apb_i.pwdata[ASC_BIT_GROUP];
      ctrl_nxt.sel   = apb_i.pwdata[3:0];
      done_nxt       = 1'b0;
      slot_nxt       = '0;
      cnt_nxt        = '0;
      dac_nxt        = '0;
      st_nxt         = susp ? ASC_SUSP : ASC_CONV;
    end
    // Group mode takes the group from the upper bits, the slot from the lower
    mux_nxt   = ctrl_nxt.group ? {ctrl_nxt.sel[3:2], slot_nxt} : ctrl_nxt.sel;
    muxen_nxt = (st_nxt == ASC_CONV) && chan_routable(mux_nxt);
    smp_nxt   = (st_nxt == ASC_CONV) && (cnt_nxt < ASC_SAMPLE_END);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= ASC_IDLE;
      cnt_r   <= '0;
      slot_r  <= '0;
      dac_r   <= '0;
      ctrl_r  <= '0;
      done_r  <= ASC_DONE_RST;
      pwr_r   <= ASC_PWR_RST;
      mux_r   <= '0;
      muxen_r <= 1'b0;
      smp_r   <= 1'b0;
      for (int i = 0; i < ASC_SLOTS; i++) begin
        res_r[i] <= '0;
      end
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      slot_r  <= slot_nxt;
      dac_r   <= dac_nxt;
      ctrl_r  <= ctrl_nxt;
      done_r  <= done_nxt;
      pwr_r   <= pwr_nxt;
      mux_r   <= mux_nxt;
      muxen_r <= muxen_nxt;
      smp_r   <= smp_nxt;
      res_r   <= res_nxt;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign mux_sel    = mux_r;
  assign mux_en     = muxen_r;
  assign sample_en  = smp_r;
  assign dac_code   = dac_r;
  assign conv_power = pwr_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic conv_end;
  assign conv_end = (st_r == ASC_CONV) && !susp && (cnt_r == ASC_CNT_LAST) && !wr_ctrl;

  property p_single_code;
    @(posedge pclk) disable iff (!presetn)
      (st_r == ASC_CONV && !ctrl_r.group) |-> mux_r == ctrl_r.sel;
  endproperty
  a_single_code: assert property (p_single_code) else $error("single channel code wrong");

  property p_group_code;
    @(posedge pclk) disable iff (!presetn)
      (st_r == ASC_CONV && ctrl_r.group) |-> mux_r == {ctrl_r.sel[3:2], slot_r};
  endproperty
  a_group_code: assert property (p_group_code) else $error("group channel code wrong");

  property p_reserved_off;
    @(posedge pclk) disable iff (!presetn)
      (mux_r[3:2] == 2'b10 || mux_r == 4'hf) |-> !mux_en;
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("reserved code routed");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && !susp) |=> st_r == ASC_CONV && cnt_r == 5'h00 && slot_r == 2'd0 && sample_en;
  endproperty
  a_restart: assert property (p_restart) else $error("write did not restart");

  property p_done_clear;
    @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> !done_r;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("write left done flag set");

  property p_slot_advance;
    @(posedge pclk) disable iff (!presetn)
      conv_end |=> slot_r == $past(slot_r) + 2'd1 && res_r[$past(slot_r)] == $past(kept);
  endproperty
  a_slot_advance: assert property (p_slot_advance) else $error("slot not filled in order");

  property p_oneshot_stop;
    @(posedge pclk) disable iff (!presetn)
      (conv_end && slot_r == 2'd3 && !ctrl_r.scan) |=> st_r == ASC_IDLE && done_r;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

  property p_scan_go_on;
    @(posedge pclk) disable iff (!presetn)
      (conv_end && slot_r == 2'd3 && ctrl_r.scan) |=> st_r == ASC_CONV && done_r;
  endproperty
  a_scan_go_on: assert property (p_scan_go_on) else $error("scan stopped or flag clear");

  property p_conv_len;
    @(posedge pclk) disable iff (!presetn)
      (st_r == ASC_CONV && cnt_r == ASC_SAMPLE_END && !susp && !wr_ctrl) |->
        !sample_en && dac_r == ASC_MSB_TRIAL;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("sampling length wrong");

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
      (st_r == ASC_SUSP && !susp && !wr_ctrl) |=> st_r == ASC_CONV && cnt_r == 5'h00 && sample_en;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not resample");

  property p_power_off;
    @(posedge pclk) disable iff (!presetn)
      !pwr_r |=> st_r != ASC_CONV && !sample_en;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converting while unpowered");

  property p_bit6_zero;
    @(posedge pclk) disable iff (!presetn)
      (pready && apb_i.psel && !apb_i.pwrite && reg_hit(apb_i.paddr, ASC_IDX_CTRL)) |-> !prdata[6];
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 read nonzero");

  property p_slot_ro;
    @(posedge pclk) disable iff (!presetn)
      (acc && apb_i.pwrite && reg_hit(apb_i.paddr, ASC_IDX_RES1) && !conv_end) |=>
        res_r[0] == $past(res_r[0]);
  endproperty
  a_slot_ro: assert property (p_slot_ro) else $error("result slot took a write");

  property p_done_hold;
    @(posedge pclk) disable iff (!presetn)
      (done_r && !wr_ctrl) |=> done_r;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag dropped");

  c_oneshot: cover property (@(posedge pclk) disable iff (!presetn)
    conv_end && slot_r == 2'd3 && !ctrl_r.scan);
  c_group_scan: cover property (@(posedge pclk) disable iff (!presetn)
    conv_end && slot_r == 2'd3 && ctrl_r.scan && ctrl_r.group);
  c_suspend: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == ASC_SUSP ##1 st_r == ASC_CONV);
  c_abandon: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && st_r == ASC_CONV && cnt_r != 5'h00);

endmodule // asc_seq_ctrl

// file: logic/asc_pkg.sv
// Shared constants and carriers for the converter sequence controller.
// Assumes an APB master with 32-bit data and a 16-bit byte address.
package asc_pkg;

  // ---------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] ASC_IDX_CTRL = 16'h1030;
  localparam logic [15:0] ASC_IDX_RES1 = 16'h1031;
  localparam logic [15:0] ASC_IDX_RES2 = 16'h1032;
  localparam logic [15:0] ASC_IDX_RES3 = 16'h1033;
  localparam logic [15:0] ASC_IDX_RES4 = 16'h1034;
  localparam logic [15:0] ASC_IDX_CFG  = 16'h1035;

  // ---------------------------------------------------------------
  // Control and config register fields and reset values
  // ---------------------------------------------------------------
  localparam int         ASC_BIT_DONE   = 7;
  localparam int         ASC_BIT_ZERO   = 6;
  localparam int         ASC_BIT_SCAN   = 5;
  localparam int         ASC_BIT_GROUP  = 4;
  localparam int         ASC_BIT_PWR    = 0;
  localparam logic       ASC_DONE_RST   = 1'b1;
  localparam logic       ASC_PWR_RST    = 1'b0;

  // ---------------------------------------------------------------
  // Channel codes
  // ---------------------------------------------------------------
  localparam logic [3:0] ASC_CH_IN_LAST = 4'h7;
  localparam logic [3:0] ASC_CH_REF_HI  = 4'hc;
  localparam logic [3:0] ASC_CH_REF_LO  = 4'hd;
  localparam logic [3:0] ASC_CH_REF_MID = 4'he;

  // ---------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------
  localparam int         ASC_RES_W      = 8;
  localparam int         ASC_SLOTS      = 4;
  localparam int         ASC_REVISIT_US = 64;
  localparam int         ASC_REF_MHZ    = 2;
  localparam int         ASC_CONV_CYC   = ASC_REVISIT_US * ASC_REF_MHZ / ASC_SLOTS;
  localparam int         ASC_SAMPLE_CYC = ASC_CONV_CYC - ASC_RES_W;
  localparam logic [4:0] ASC_CNT_LAST   = 5'(ASC_CONV_CYC - 1);
  localparam logic [4:0] ASC_SAMPLE_END = 5'(ASC_SAMPLE_CYC);
  localparam logic [4:0] ASC_SAMPLE_LST = 5'(ASC_SAMPLE_CYC - 1);
  localparam logic [7:0] ASC_MSB_TRIAL  = 8'h80;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } asc_apb_req_t;

  typedef struct packed {
    logic       scan;
    logic       group;
    logic [3:0] sel;
  } asc_ctrl_t;

  typedef enum logic [1:0] {ASC_IDLE, ASC_CONV, ASC_SUSP} asc_state_t;

endpackage

// file: dv/test_adc_sequence_control.sv
// Self-checking bench for the converter sequence controller.
// Assumes the APB slave answers without wait states and a comparator fed
// from a per-channel table of levels that the bench randomises.
`timescale 1ns/100ps
module test_adc_sequence_control;
  import asc_pkg::*;

  localparam logic [15:0] A_CTRL = ASC_IDX_CTRL << 2;
  localparam logic [15:0] A_RES1 = ASC_IDX_RES1 << 2;
  localparam logic [15:0] A_CFG  = ASC_IDX_CFG << 2;

  logic         pclk;
  logic         presetn;
  logic         halt_req;
  logic         idle_req;
  logic         cmp_above;
  asc_apb_req_t apb_i;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [3:0]   mux_sel;
  logic         mux_en;
  logic         sample_en;
  logic [7:0]   dac_code;
  logic         conv_power;
  logic [7:0]   ana [16];
  logic [7:0]   m_ctrl = 8'h00;
  logic [7:0]   c;
  logic [31:0]  rd;
  logic         er;
  logic         se_q = 1'b0;
  bit           mon_off;
  bit           wr_q;
  int           seed = 70;
  int           miscompares = 0;
  int           checks_done = 0;
  int           cyc = 0;
  int           t_wr = 0;
  int           t_rise = 0;
  int           mon_k = 0;
  int           nrise = 0;

  asc_seq_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .apb_i(apb_i), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_req(halt_req), .idle_req(idle_req), .cmp_above(cmp_above),
    .mux_sel(mux_sel), .mux_en(mux_en), .sample_en(sample_en), .dac_code(dac_code),
    .conv_power(conv_power)
  );

  // Comparator: input level at or above the trial value
  assign cmp_above = (ana[mux_sel] >= dac_code);

  // ---------------------------------------------------------------
  // Model helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] code_of(input logic [7:0] cv, input int n);
    return cv[4] ? {cv[3:2], 2'(n)} : cv[3:0];
  endfunction

  function automatic logic routable(input logic [3:0] cd);
    return (cd <= 4'h7) || (cd >= 4'hc && cd <= 4'he);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic rnd_ana;
    for (int i = 0; i < 16; i++) ana[i] <= 8'($random(seed));
  endtask

  // ---------------------------------------------------------------
  // APB master
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite  <= w;
    apb_i.paddr   <= a;
    apb_i.pwdata  <= d;
    @(posedge pclk);
    apb_i.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, A_CTRL, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 150);
    if (rd[7] !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic chk_res;
    for (int n = 0; n < 4; n++) begin
      apb(1'b0, A_RES1 + 16'(4 * n), 32'h0);
      chk(rd, {24'h0, ana[code_of(m_ctrl, n)]});
    end
  endtask

  // ---------------------------------------------------------------
  // Conversion start monitor
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // A write restarts the sequence even while sampling stays high
    if (presetn && sample_en && (!se_q || wr_q)) begin
      nrise++;
      if (!mon_off) begin
        chk(mux_sel, code_of(m_ctrl, mon_k % 4));
        chk(mux_en, routable(code_of(m_ctrl, mon_k % 4)));
        chk(cyc, mon_k == 0 ? t_wr + 1 : t_rise + ASC_CONV_CYC);
      end
      mon_k++;
      t_rise = cyc;
    end
    se_q = sample_en;
    wr_q = 1'b0;
    if (apb_i.psel && apb_i.penable && pready && apb_i.pwrite && apb_i.paddr == A_CTRL) begin
      t_wr   = cyc;
      mon_k  = 0;
      nrise  = 0;
      m_ctrl = apb_i.pwdata[7:0];
      wr_q   = 1'b1;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn  = 1'b0;
    apb_i    = '0;
    halt_req = 1'b0;
    idle_req = 1'b0;
    mon_off  = 1'b0;
    for (int i = 0; i < 16; i++) ana[i] = 8'(i);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, 16'h4100, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    // Converter unpowered: nothing starts until power is applied
    mon_off = 1'b1;
    rnd_ana();
    apb(1'b1, A_CTRL, 32'h05);
    idle(40);
    chk(nrise, 0);
    chk(conv_power, 1'b0);
    apb(1'b1, A_CFG, 32'h1);
    idle(1);
    chk(conv_power, 1'b1);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h1);
    wait_done();
    chk_res();
    mon_off = 1'b0;
    // Every mode against every code or group
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 16; s += ((m & 1) ? 4 : 1)) begin
        c = 8'hc0 | 8'(m << 4) | 8'(s);
        if (m & 1) c = c | (8'($random(seed)) & 8'h03);
        rnd_ana();
        apb(1'b1, A_CTRL, {24'h0, c});
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, {24'h0, c & 8'h3f});
        wait_done();
        chk(rd, {24'h0, 8'h80 | (c & 8'h3f)});
        chk_res();
        if (m < 2) begin
          idle(64);
          chk(nrise, 4);
        end else begin
          rnd_ana();
          idle(300);
          chk_res();
          apb(1'b0, A_CTRL, 32'h0);
          chk(rd, {24'h0, 8'h80 | (c & 8'h3f)});
        end
      end
    end
    // Result slots refuse writes while scanning continues
    apb(1'b1, A_RES1, 32'h5a);
    chk(er, 1'b0);
    chk_res();
    // Halt and idle mid-sequence restart the current channel
    mon_off = 1'b1;
    rnd_ana();
    apb(1'b1, A_CTRL, 32'h03);
    idle(40);
    halt_req <= 1'b1;
    idle(10);
    chk(sample_en, 1'b0);
    halt_req <= 1'b0; // immediate exit assumed, so no settling wait is kept
    idle(20);
    idle_req <= 1'b1;
    idle(10);
    chk(sample_en, 1'b0);
    idle_req <= 1'b0;
    wait_done();
    chk_res();
    chk(nrise, 6);
    finish_test();
  end

endmodule // test_adc_sequence_control
